// >>> inc/reset_controller_params.svh
/*
 * constants of the reset controller: register indices, field positions,
 * reset values and timing counts.
 * assumes a 40 MHz system clock and a 32-bit register bus.
 */
// Notes on behaviour
// - enabled reset pin holds reset while low
// - watchdog time-out request issues device reset
// - software trigger write starts reset immediately
// - software trigger bit always reads zero
// - debug reset request only from debug port
// - all resets reload fuses; debug logic power-only
// - internal initialization after all sources release
// - start-up time added only after power resets
// - start-up memory scan extends initialization
// - works in active and every sleep mode
// - write without unlock leaves register unchanged
// - software trigger guarded by io register key
// - cause flags clear on one, zero ignored
// - power-on clears all flags but power-on flag
// - no other flag until full boot completes
// - flag bits: debug5 sw4 wdt3 ext2 bod1 por0
// - unused brown-out forced to minimum level
// - some sources need fuse or software enable
`ifndef RESET_CONTROLLER_PARAMS_SVH
`define RESET_CONTROLLER_PARAMS_SVH

// ************************************************************
// register map
// ************************************************************
`define IDX_CAUSE_FLAGS 6'h00
`define IDX_SW_TRIGGER 6'h01
`define FLAG_DEBUG_BIT 5
`define FLAG_SW_BIT 4
`define FLAG_WDT_BIT 3
`define FLAG_EXT_BIT 2
`define FLAG_BOD_BIT 1
`define FLAG_POR_BIT 0
`define FLAGS_WIDTH 6
`define FLAGS_POR_VALUE 6'h01
`define SW_TRIGGER_BIT 0

// ************************************************************
// fuse encodings
// ************************************************************
`define SCAN_SRC_NONE 2'h3
`define BOD_LEVEL_MIN 3'h0

// ************************************************************
// timing
// ************************************************************
`define CLK_PERIOD_NS 25
`define SUT_UNIT_US 1000
`define SUT_UNIT_CYCLES ((`SUT_UNIT_US * 1000) / `CLK_PERIOD_NS)
`define INIT_TIME_NS 50
`define INIT_CYCLES ((`INIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> inc/reset_controller_pkg.sv
/*
 * types of the reset controller: sequence states and state records.
 * assumes reset_controller_params.svh for all numbers.
 */
package reset_controller_pkg;

    // ************************************************************
    // reset sequence states
    // ************************************************************
    typedef enum logic [5:0] {
        ST_HOLD = 6'b000001,
        ST_FUSE = 6'b000010,
        ST_SUT = 6'b000100,
        ST_SCAN = 6'b001000,
        ST_INIT = 6'b010000,
        ST_RUN = 6'b100000
    } seq_state_t;

    // ************************************************************
    // state of the controller
    // ************************************************************
    typedef struct packed {
        seq_state_t st;
        logic [31:0] cnt;
        logic power_rst;
        logic boot_done;
        logic [5:0] flags;
        logic ap_valid;
        logic ap_write;
        logic [5:0] ap_index;
        logic [31:0] rdata;
    } ctrl_state_t;

endpackage

// >>> src/pin_sync.sv
/*
 * two-stage synchroniser for a group of asynchronous inputs.
 * assumes one clock; idle value of each input given by a parameter.
 */
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] IDLE = '0
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;

    always_comb begin
        state_next = state_reg;
        state_next.meta = async_in;
        state_next.stable = state_reg.meta;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= {IDLE, IDLE};
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.stable;

endmodule

// >>> src/reset_controller.sv
/*
 * reset controller: merges power and user reset sources, runs the
 * fuse reload, start-up delay, memory scan and initialization phases,
 * records the cause and offers a protected software trigger on ahb-lite.
 * assumes reset_n is the power-on reset; pins and the debug port are
 * asynchronous; watchdog request and unlock window come on clk_sys.
 */
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "reset_controller_params.svh"
module reset_controller #(
    parameter int SUT_UNIT_CYCLES = `SUT_UNIT_CYCLES,
    parameter int INIT_CYCLES = `INIT_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic ext_reset_pin_n,
    input wire logic reset_pin_function_fuse,
    input wire logic bod_reset_req,
    input wire logic bod_used_fuse,
    input wire logic [2:0] bod_level_fuse,
    output logic [2:0] bod_level,
    input wire logic wdt_reset_req,
    input wire logic debug_port_reset_req,
    input wire logic io_register_unlocked,
    input wire logic [2:0] startup_time_fuse,
    input wire logic [1:0] startup_scan_source_fuse,
    output logic fuse_reload_req,
    input wire logic fuse_reload_done,
    output logic scan_start_req,
    input wire logic scan_done,
    output logic sys_reset_n,
    output logic debug_reset_n
);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] sut_cycles(input logic [2:0] code);
        logic [31:0] unit;
        unit = 32'(SUT_UNIT_CYCLES);
        if (code == 3'h0) begin
            sut_cycles = 32'h0000_0000;
        end else begin
            sut_cycles = unit << (code - 3'h1);
        end
    endfunction

    function automatic logic [31:0] countdown(input logic [31:0] value);
        if (value == 32'h0000_0000) begin
            countdown = 32'h0000_0000;
        end else begin
            countdown = value - 32'h0000_0001;
        end
    endfunction

    // ************************************************************
    // input synchronisation
    // ************************************************************
    logic [2:0] pins_sync;
    logic ext_pin_n_s;
    logic bod_req_s;
    logic debug_req_s;

    pin_sync #(
        .WIDTH(3),
        .IDLE(3'h4)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .async_in({ext_reset_pin_n, bod_reset_req, debug_port_reset_req}),
        .sync_out(pins_sync)
    );

    assign ext_pin_n_s = pins_sync[2];
    assign bod_req_s = pins_sync[1];
    assign debug_req_s = pins_sync[0];

    // ************************************************************
    // state
    // ************************************************************
    reset_controller_pkg::ctrl_state_t state_reg;
    reset_controller_pkg::ctrl_state_t state_next;

    logic wr_flags;
    logic wr_trigger;
    logic ext_req;
    logic sw_req;
    logic any_req;
    logic scan_enabled;
    logic [5:0] causes;
    logic [5:0] flag_clear;
    logic ap_take;

    always_comb begin
        // data-phase write decode
        wr_flags = state_reg.ap_valid && state_reg.ap_write
            && (state_reg.ap_index == `IDX_CAUSE_FLAGS);
        wr_trigger = state_reg.ap_valid && state_reg.ap_write
            && (state_reg.ap_index == `IDX_SW_TRIGGER);
        ext_req = reset_pin_function_fuse && !ext_pin_n_s;
        // trigger only takes effect inside the unlock window
        sw_req = wr_trigger && hwdata[`SW_TRIGGER_BIT]
            && io_register_unlocked;
        // debug request has no path from the bus side
        any_req = ext_req || bod_req_s || wdt_reset_req || debug_req_s
            || sw_req;
        scan_enabled = (startup_scan_source_fuse != `SCAN_SRC_NONE);
        causes = 6'h00;
        causes[`FLAG_DEBUG_BIT] = debug_req_s;
        causes[`FLAG_SW_BIT] = sw_req;
        causes[`FLAG_WDT_BIT] = wdt_reset_req;
        causes[`FLAG_EXT_BIT] = ext_req;
        causes[`FLAG_BOD_BIT] = bod_req_s;
        flag_clear = wr_flags ? hwdata[5:0] : 6'h00;
        ap_take = hsel && hready && htrans[1];
    end

    always_comb begin
        state_next = state_reg;

        // ********************************************************
        // bus address phase
        // ********************************************************
        state_next.ap_valid = ap_take;
        state_next.ap_write = hwrite;
        state_next.ap_index = haddr[7:2];
        if (ap_take && !hwrite) begin
            state_next.rdata = 32'h0000_0000;
            if (haddr[7:2] == `IDX_CAUSE_FLAGS && haddr[31:8] == 24'h00_0000) begin
                state_next.rdata[5:0] = state_reg.flags;
            end
            // software trigger reads as zero
        end

        // ********************************************************
        // cause flags: clear first so a new cause wins
        // ********************************************************
        state_next.flags = state_reg.flags & ~flag_clear;
        if (state_reg.boot_done) begin
            state_next.flags = state_next.flags | causes;
        end

        // ********************************************************
        // reset sequence
        // ********************************************************
        if (any_req) begin
            state_next.st = reset_controller_pkg::ST_HOLD;
            state_next.cnt = 32'h0000_0000;
            if (bod_req_s) begin
                state_next.power_rst = 1'b1;
            end
        end else begin
            unique case (state_reg.st)
                reset_controller_pkg::ST_HOLD: begin
                    state_next.st = reset_controller_pkg::ST_FUSE;
                end
                reset_controller_pkg::ST_FUSE: begin
                    if (fuse_reload_done) begin
                        state_next.st = reset_controller_pkg::ST_SUT;
                        state_next.cnt = state_reg.power_rst
                            ? sut_cycles(startup_time_fuse) : 32'h0000_0000;
                    end
                end
                reset_controller_pkg::ST_SUT: begin
                    if (state_reg.cnt == 32'h0000_0000) begin
                        if (scan_enabled) begin
                            state_next.st = reset_controller_pkg::ST_SCAN;
                        end else begin
                            state_next.st = reset_controller_pkg::ST_INIT;
                            state_next.cnt = 32'(INIT_CYCLES - 1);
                        end
                    end else begin
                        state_next.cnt = countdown(state_reg.cnt);
                    end
                end
                reset_controller_pkg::ST_SCAN: begin
                    if (scan_done) begin
                        state_next.st = reset_controller_pkg::ST_INIT;
                        state_next.cnt = 32'(INIT_CYCLES - 1);
                    end
                end
                reset_controller_pkg::ST_INIT: begin
                    if (state_reg.cnt == 32'h0000_0000) begin
                        state_next.st = reset_controller_pkg::ST_RUN;
                        state_next.boot_done = 1'b1;
                        state_next.power_rst = 1'b0;
                    end else begin
                        state_next.cnt = countdown(state_reg.cnt);
                    end
                end
                reset_controller_pkg::ST_RUN: begin
                    state_next.st = reset_controller_pkg::ST_RUN;
                end
                default: begin
                    state_next.st = reset_controller_pkg::ST_HOLD;
                end
            endcase
        end
    end

    // ************************************************************
    // registers: no clock gating, runs in every sleep mode
    // ************************************************************
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_reg.st <= reset_controller_pkg::ST_HOLD;
            state_reg.cnt <= 32'h0000_0000;
            state_reg.power_rst <= 1'b1;
            state_reg.boot_done <= 1'b0;
            state_reg.flags <= `FLAGS_POR_VALUE;
            state_reg.ap_valid <= 1'b0;
            state_reg.ap_write <= 1'b0;
            state_reg.ap_index <= 6'h00;
            state_reg.rdata <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = state_reg.rdata;
    assign fuse_reload_req = (state_reg.st == reset_controller_pkg::ST_FUSE);
    assign scan_start_req = (state_reg.st == reset_controller_pkg::ST_SCAN);
    assign sys_reset_n = (state_reg.st == reset_controller_pkg::ST_RUN);
    // debug logic sees only power-supply resets
    assign debug_reset_n = !(state_reg.power_rst
        && state_reg.st != reset_controller_pkg::ST_RUN);
    assign bod_level = bod_used_fuse ? bod_level_fuse : `BOD_LEVEL_MIN;

endmodule

// >>> bench/reset_controller_properties.sv
/*
 * port checker of the reset controller.
 * assumes it is bound onto reset_controller and sees only its ports.
 */
`timescale 1ns/1ps
module reset_controller_properties (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic ext_reset_pin_n,
    input wire logic reset_pin_function_fuse,
    input wire logic bod_reset_req,
    input wire logic bod_used_fuse,
    input wire logic [2:0] bod_level_fuse,
    input wire logic [2:0] bod_level,
    input wire logic wdt_reset_req,
    input wire logic io_register_unlocked,
    input wire logic [2:0] startup_time_fuse,
    input wire logic fuse_reload_req,
    input wire logic scan_start_req,
    input wire logic scan_done,
    input wire logic sys_reset_n,
    input wire logic debug_reset_n
);
    // ************************************************************
    // assertions
    // ************************************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence s_addr(logic [5:0] idx, logic wr);
        hsel && hready && htrans[1] && hwrite == wr && haddr[7:2] == idx;
    endsequence
    sequence s_trigger;
        s_addr(6'h01, 1'b1) ##1 (io_register_unlocked && hwdata[0]);
    endsequence
    a_trigger_resets: assert property (s_trigger |=> !sys_reset_n)
        else $error("unlocked trigger write gave no reset");
    a_trigger_reads_zero: assert property (s_addr(6'h01, 1'b0) |=> hrdata == 32'h0)
        else $error("trigger register read not zero");
    a_flags_upper_zero: assert property (s_addr(6'h00, 1'b0) |=> hrdata[31:6] == 26'h0)
        else $error("flag read has bits above five");
    a_wdt_resets: assert property (wdt_reset_req |=> !sys_reset_n)
        else $error("watchdog request gave no reset");
    a_pin_resets: assert property
        ((reset_pin_function_fuse && !ext_reset_pin_n) [*4] |-> !sys_reset_n)
        else $error("low reset pin gave no reset");
    a_debug_kept: assert property
        (wdt_reset_req && debug_reset_n && !bod_reset_req |=> debug_reset_n)
        else $error("user reset reset the debug logic");
    a_debug_in_reset: assert property (!debug_reset_n |-> !sys_reset_n)
        else $error("debug reset outside device reset");
    a_phases_done: assert property ($rose(sys_reset_n) |->
        $past(fuse_reload_req) == 1'b0 && $past(scan_start_req) == 1'b0)
        else $error("reset left before fuse or scan phase ended");
    a_scan_holds: assert property (scan_start_req && !scan_done |=> !sys_reset_n)
        else $error("reset left while scan running");
    a_bod_level_min: assert property
        (bod_level == (bod_used_fuse ? bod_level_fuse : 3'h0))
        else $error("brown-out level wrong");
    a_user_no_sut: assert property
        ($fell(fuse_reload_req) && debug_reset_n |-> ##[1:3] (scan_start_req || sys_reset_n))
        else $error("start-up delay added after user reset");
    a_power_sut: assert property
        ($fell(fuse_reload_req) && !debug_reset_n && startup_time_fuse != 3'h0
        |=> !scan_start_req && !sys_reset_n)
        else $error("start-up delay missing after power reset");
endmodule

bind reset_controller reset_controller_properties chk_u (.*);

// >>> bench/boot_helpers_model.sv
/*
 * far-side model: fuse loader and memory scanner.
 * assumes one clock; answer delay in cycles is set by the bench.
 */
`timescale 1ns/1ps
module boot_helpers_model (
    input wire logic clk_sys,
    input wire logic [3:0] delay,
    input wire logic fuse_reload_req,
    input wire logic scan_start_req,
    output logic fuse_reload_done,
    output logic scan_done
);
    logic [3:0] fuse_cnt = 4'h0;
    logic [3:0] scan_cnt = 4'h0;
    // done only after the request has stood delay cycles
    always_ff @(posedge clk_sys) begin
        fuse_cnt <= fuse_reload_req ? fuse_cnt + 4'h1 : 4'h0;
        scan_cnt <= scan_start_req ? scan_cnt + 4'h1 : 4'h0;
    end
    assign fuse_reload_done = fuse_reload_req && (fuse_cnt >= delay);
    assign scan_done = scan_start_req && (scan_cnt >= delay);
endmodule

// >>> bench/reset_controller_tb.sv
/*
 * self-checking bench of the reset controller.
 * assumes the checker is bound in and the helper model answers.
 */
`timescale 1ns/1ps
module reset_controller_tb;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, fuse_req, fuse_done, scan_req, scan_done;
    logic sys_reset_n, debug_reset_n;
    logic [31:0] hrdata;
    logic [2:0] bod_level;
    logic [3:0] srcs = 4'h0;
    logic pin_fuse = 1'b1;
    logic bod_used = 1'b1;
    logic [2:0] bod_lvl = 3'h5;
    logic unlocked = 1'b0;
    logic [1:0] scan_src = 2'h3;
    logic [3:0] delay = 4'h2;
    logic rd_phase = 1'b0;
    logic [31:0] seed = 32'hA985FF1D;
    logic [31:0] exp_q[$];
    logic [5:0] flag_of [5] = '{6'h10, 6'h08, 6'h04, 6'h20, 6'h02};
    int fail_count = 0;
    int num_checks = 0;

    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    reset_controller #(.SUT_UNIT_CYCLES(4), .INIT_CYCLES(2)) dut_u (
        .clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
        .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .ext_reset_pin_n(~srcs[1]), .reset_pin_function_fuse(pin_fuse),
        .bod_reset_req(srcs[3]), .bod_used_fuse(bod_used), .bod_level_fuse(bod_lvl),
        .bod_level(bod_level), .wdt_reset_req(srcs[0]), .debug_port_reset_req(srcs[2]),
        .io_register_unlocked(unlocked), .startup_time_fuse(3'h1),
        .startup_scan_source_fuse(scan_src), .fuse_reload_req(fuse_req),
        .fuse_reload_done(fuse_done), .scan_start_req(scan_req), .scan_done(scan_done),
        .sys_reset_n(sys_reset_n), .debug_reset_n(debug_reset_n));

    boot_helpers_model model_u (.clk_sys(clk_sys), .delay(delay),
        .fuse_reload_req(fuse_req), .scan_start_req(scan_req),
        .fuse_reload_done(fuse_done), .scan_done(scan_done));

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task check_bit(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask

    task check_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t read %h expected %h", $time, got, exp);
        end
    endtask

    task bus_cycle(input logic [31:0] a, input logic wr, input logic [31:0] d, input logic unl);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        unlocked <= unl;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        unlocked <= 1'b0;
    endtask

    task bus_read(input logic [31:0] a, input logic [31:0] exp);
        exp_q.push_back(exp);
        bus_cycle(a, 1'b0, 32'h0, 1'b0);
    endtask

    task wait_boot;
        int n;
        n = 0;
        while (sys_reset_n !== 1'b1 && n < 3000) begin
            @(posedge clk_sys);
            n++;
        end
        check_bit(sys_reset_n, 1'b1, "boot did not finish");
    endtask

    task conclude;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        if (rd_phase && exp_q.size() > 0) check_word(hrdata, exp_q.pop_front());
        rd_phase <= hsel && htrans[1] && !hwrite && hreadyout;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        $display("MISMATCH %0t watchdog expired", $time);
        conclude();
    end

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        wait_boot();
        check_bit(debug_reset_n, 1'b1, "debug logic held");
        bus_read(32'h0, 32'h1);
        bus_read(32'h4, 32'h0);
        bus_read(32'h8, 32'h0);
        bus_cycle(32'h0, 1'b1, 32'h0, 1'b0);
        bus_read(32'h0, 32'h1);
        bus_cycle(32'h4, 1'b1, 32'h1, 1'b0);
        repeat (2) @(posedge clk_sys);
        check_bit(sys_reset_n, 1'b1, "locked trigger reset");
        $display("register test done");
        pin_fuse <= 1'b0;
        srcs <= 4'h2;
        repeat (6) @(posedge clk_sys);
        check_bit(sys_reset_n, 1'b1, "disabled pin reset");
        srcs <= 4'h0;
        repeat (3) @(posedge clk_sys);
        pin_fuse <= 1'b1;
        $display("pin disable test done");
        for (int k = 0; k < 5; k++) begin
            seed = xorshift(seed);
            scan_src <= k[0] ? 2'h0 : 2'h3;
            delay <= seed[3:0] & 4'h7;
            bod_used <= seed[4];
            bod_lvl <= seed[7:5];
            if (k == 0) bus_cycle(32'h4, 1'b1, 32'h1, 1'b1);
            else begin
                @(posedge clk_sys);
                srcs <= 4'h1 << (k - 1);
                repeat (5) @(posedge clk_sys);
            end
            @(negedge clk_sys);
            check_bit(sys_reset_n, 1'b0, "source gave no reset");
            @(posedge clk_sys);
            srcs <= 4'h0;
            wait_boot();
            bus_read(32'h0, {26'h0, flag_of[k] | 6'h01});
            bus_cycle(32'h0, 1'b1, {26'h0, flag_of[k]}, 1'b0);
            bus_read(32'h0, 32'h1);
            $display("source %0d test done", k);
        end
        seed = xorshift(seed);
        bus_cycle(32'h0, 1'b1, seed, 1'b0);
        bus_read(32'h0, {31'h0, ~seed[0]});
        bus_cycle(32'h4, 1'b1, 32'h1, 1'b1);
        @(negedge clk_sys);
        check_bit(sys_reset_n, 1'b0, "unlocked trigger gave no reset");
        wait_boot();
        reset_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        srcs <= 4'h1;
        repeat (3) @(posedge clk_sys);
        srcs <= 4'h0;
        wait_boot();
        bus_read(32'h0, 32'h1);
        repeat (3) @(posedge clk_sys);
        $display("power-on test done");
        conclude();
    end
endmodule
